// file: inc/pap_pkg.sv
// Constants, decode functions and state type of the pixel path block.
package pap_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PATTERN = 8'h04;
  localparam logic [7:0] OFF_COL_START = 8'h08;
  localparam logic [7:0] OFF_ROW_START = 8'h0c;
  localparam logic [7:0] OFF_CROP_W = 8'h10;
  localparam logic [7:0] OFF_CROP_H = 8'h14;
  localparam logic [7:0] OFF_MAX_COLS = 8'h18;
  localparam logic [7:0] OFF_MAX_ROWS = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_MIRROR_COLS = 0;
  localparam int CTRL_MIRROR_ROWS = 1;
  localparam int CTRL_DEPTH_LSB = 2;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_SOURCE = 6;
  localparam logic [6:0] CTRL_RESET = 7'h34;
  localparam logic [1:0] DEPTH_10 = 2'h0;
  localparam logic [1:0] DEPTH_12 = 2'h1;
  localparam logic [1:0] DEPTH_14 = 2'h2;
  localparam logic [1:0] FMT_8 = 2'h0;
  localparam logic [1:0] FMT_10 = 2'h1;
  localparam logic [1:0] FMT_12 = 2'h2;
  localparam logic [1:0] KIND_OFF = 2'h0;
  localparam logic [1:0] KIND_SENSOR = 2'h1;
  localparam logic [1:0] KIND_INCREMENT = 2'h2;
  localparam logic [1:0] LAYOUT_RG = 2'h0;

  typedef enum logic [3:0] {
    ST_FILL = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_SEND = 4'b1000
  } pap_state_e;

  // Number of converter bits for a depth code.
  function automatic logic [4:0] pap_depth_bits(input logic [1:0] sel);
    case (sel)
      DEPTH_10: pap_depth_bits = 5'd10;
      DEPTH_14: pap_depth_bits = 5'd14;
      default: pap_depth_bits = 5'd12;
    endcase
  endfunction

  // Bits of the 16-bit word that the output format keeps.
  function automatic logic [15:0] pap_fmt_mask(input logic [1:0] sel);
    case (sel)
      FMT_8: pap_fmt_mask = 16'hff00;
      FMT_10: pap_fmt_mask = 16'hffc0;
      FMT_12: pap_fmt_mask = 16'hfff0;
      default: pap_fmt_mask = 16'hffff;
    endcase
  endfunction

endpackage

// file: logic/pap_align.sv
// Left alignment of a converter sample into a 16-bit word.
`timescale 1ns/1ps
module pap_align
  import pap_pkg::*;
(
  input wire logic [13:0] sample,
  input wire logic [1:0] depth_sel,
  input wire logic [1:0] fmt_sel,
  output logic [15:0] aligned
);
  // Shifting by 16 minus depth pushes stray high bits out of the word.
  wire logic [4:0] shift = 5'd16 - pap_depth_bits(depth_sel);
  wire logic [15:0] left = 16'({2'h0, sample} << shift);
  assign aligned = left & pap_fmt_mask(fmt_sel);
endmodule

// file: logic/pap_frame_store.sv
// Frame memory with one write port and one registered read port.
`timescale 1ns/1ps
module pap_frame_store #(
  parameter int DW = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Write and read in the same cycle; a read sees the old word.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: logic/pap_pixel_path.sv
// Pixel path: alignment, test patterns, mirroring, crop and APB registers.
// Notes on behaviour
// - Narrow output formats drop surplus low sample bits.
// - Samples sit at the top of a 16-bit word, low bits filler.
// - A 12-bit sample occupies mask 0xfff0, low four bits zero.
// - Full scale is 65472, 65520, 65532 for 10, 12, 14 bits.
// - A source select picks which generator the pattern kind controls.
// - The pipeline-head generator replaces pixels at the first stage.
// - Writing Off disables only the currently selected generator.
// - The sensor generator is enabled only by the sensor pattern value.
// - Increment pattern adds one per pixel, 8-bit, wraps after 255.
// - Both generators may run; the pipeline-head pattern wins.
// - Later processing stays active and may alter pattern pixels.
// - Exposure, gain and black level never change pattern pixels.
// - Real pixels pass only with both generators off.
// - Only pixels inside the offset and size rectangle leave.
// - Region size is limited to frame maximum minus offset.
// - Frame maximum is fixed, independent of the region.
// - Column mirroring happens before the crop.
// - Column mirroring changes the reported colour layout RG to GR.
// - Row mirroring happens before the crop.
// - Row mirroring changes the reported colour layout RG to GB.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module pap_pixel_path
  import pap_pkg::*;
#(
  parameter int MAX_COLS = 2064,
  parameter int MAX_ROWS = 1544,
  parameter logic [1:0] BASE_LAYOUT = LAYOUT_RG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic pix_valid,
  input wire logic [13:0] pix_data,
  input wire logic pix_sof,
  input wire logic pix_eol,
  output logic pix_ready,
  output logic out_valid,
  output logic [15:0] out_data,
  output logic out_sof,
  output logic out_eol,
  input wire logic out_ready,
  output logic [1:0] bayer_layout
);
  localparam int AW = $clog2(MAX_COLS * MAX_ROWS);
  localparam logic [15:0] MAXC = 16'(MAX_COLS);
  localparam logic [15:0] MAXR = 16'(MAX_ROWS);

  pap_state_e state;
  pap_state_e next_state;
  logic [6:0] ctrl;
  logic pat_sensor_en;
  logic pat_pipe_en;
  logic [15:0] col_start;
  logic [15:0] row_start;
  logic [15:0] crop_w;
  logic [15:0] crop_h;
  logic [1:0] depth_lat;
  logic in_frame;
  logic [15:0] in_col;
  logic [15:0] in_row;
  logic [7:0] grey_cnt;
  logic [15:0] dr_col;
  logic [15:0] dr_row;
  logic [15:0] aligned;
  logic [15:0] rdata;

  // ****************************************
  // APB decode
  // ****************************************

  // Address matches and the access strobes; a write lands with pready.
  wire logic apb_acc = psel & penable;
  wire logic wr_en = apb_acc & pwrite & pready;
  wire logic sel_ctrl = (paddr == OFF_CTRL);
  wire logic sel_pat = (paddr == OFF_PATTERN);
  wire logic sel_cs = (paddr == OFF_COL_START);
  wire logic sel_rs = (paddr == OFF_ROW_START);
  wire logic sel_w = (paddr == OFF_CROP_W);
  wire logic sel_h = (paddr == OFF_CROP_H);
  wire logic sel_mc = (paddr == OFF_MAX_COLS);
  wire logic sel_mr = (paddr == OFF_MAX_ROWS);
  wire logic sel_st = (paddr == OFF_STATUS);
  wire logic hit = sel_ctrl | sel_pat | sel_cs | sel_rs | sel_w | sel_h |
                   sel_mc | sel_mr | sel_st;
  wire logic src_pipe = ctrl[CTRL_SOURCE];
  wire logic [1:0] wr_kind = pwdata[1:0];

  // Read-back of the pattern kind follows the selected generator.
  wire logic [1:0] sensor_kind = pat_sensor_en ? KIND_SENSOR : KIND_OFF;
  wire logic [1:0] pipe_kind = pat_pipe_en ? KIND_INCREMENT : KIND_OFF;
  wire logic [1:0] cur_kind = src_pipe ? pipe_kind : sensor_kind;
  wire logic draining = (state != ST_FILL);
  wire logic [31:0] status_word = {27'h0, bayer_layout, pat_pipe_en,
                                   pat_sensor_en, draining};

  // Read data multiplexer; unmapped offsets read as zero.
  wire logic [31:0] rd_word =
    sel_ctrl ? {25'h0, ctrl} :
    sel_pat ? {30'h0, cur_kind} :
    sel_cs ? {16'h0, col_start} :
    sel_rs ? {16'h0, row_start} :
    sel_w ? {16'h0, crop_w} :
    sel_h ? {16'h0, crop_h} :
    sel_mc ? {16'h0, MAXC} :
    sel_mr ? {16'h0, MAXR} :
    sel_st ? status_word : 32'h0;

  // ****************************************
  // Crop window and mirroring
  // ****************************************

  // Room left after the offset bounds the effective region size.
  wire logic [15:0] room_c = (col_start < MAXC) ? MAXC - col_start : 16'h0;
  wire logic [15:0] room_r = (row_start < MAXR) ? MAXR - row_start : 16'h0;
  wire logic [15:0] eff_w = (crop_w > room_c) ? room_c : crop_w;
  wire logic [15:0] eff_h = (crop_h > room_r) ? room_r : crop_h;
  wire logic crop_empty = (eff_w == 16'h0) | (eff_h == 16'h0);

  // Region coordinates live in the flipped image; map back to storage.
  wire logic [15:0] flip_c = col_start + dr_col;
  wire logic [15:0] flip_r = row_start + dr_row;
  wire logic [15:0] src_c = ctrl[CTRL_MIRROR_COLS] ?
                            MAXC - 16'h1 - flip_c : flip_c;
  wire logic [15:0] src_r = ctrl[CTRL_MIRROR_ROWS] ?
                            MAXR - 16'h1 - flip_r : flip_r;
  wire logic [AW-1:0] raddr =
    AW'(32'(src_r) * 32'(MAX_COLS) + 32'(src_c));
  wire logic last_col = (dr_col == eff_w - 16'h1);
  wire logic last_row = (dr_row == eff_h - 16'h1);

  // ****************************************
  // Input side: alignment and test patterns
  // ****************************************

  // Position of the offered pixel; a start-of-frame pixel is the origin.
  wire logic take = pix_valid & pix_ready;
  wire logic [15:0] cur_col = pix_sof ? 16'h0 : in_col;
  wire logic [15:0] cur_row = pix_sof ? 16'h0 : in_row;
  wire logic in_bounds = (cur_col < MAXC) & (cur_row < MAXR);
  wire logic live = take & (in_frame | pix_sof);
  wire logic frame_done = live & pix_eol & (cur_row == MAXR - 16'h1);

  // Sensor-side ramp ignores the incoming sample entirely.
  wire logic [13:0] sensor_pat = 14'(cur_col + cur_row);
  wire logic [13:0] raw = pat_sensor_en ? sensor_pat : pix_data;
  wire logic [1:0] depth_now =
    pix_sof ? ctrl[CTRL_DEPTH_LSB +: 2] : depth_lat;

  pap_align i_pap_align (
    .sample(raw),
    .depth_sel(depth_now),
    .fmt_sel(ctrl[CTRL_FMT_LSB +: 2]),
    .aligned(aligned)
  );

  // Pipeline-head pattern overrides everything at the first stage.
  wire logic [7:0] grey = pix_sof ? 8'h00 : grey_cnt;
  wire logic [15:0] stored =
    pat_pipe_en ? {grey, 8'h00} : aligned;
  wire logic we = live & in_bounds;
  wire logic [AW-1:0] waddr =
    AW'(32'(cur_row) * 32'(MAX_COLS) + 32'(cur_col));

  pap_frame_store #(
    .DW(16),
    .DEPTH(MAX_COLS * MAX_ROWS),
    .AW(AW)
  ) i_pap_frame_store (
    .clk(pclk),
    .we(we),
    .waddr(waddr),
    .wdata(stored),
    .raddr(raddr),
    .rdata(rdata)
  );

  // ****************************************
  // Sequencing
  // ****************************************

  // Fill a whole frame, then read the region out one pixel at a time.
  always_comb begin
    next_state = state;
    case (state)
      ST_FILL: begin
        if (frame_done & ~crop_empty) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_SEND;
      ST_SEND: begin
        if (out_ready) begin
          next_state = (last_col & last_row) ? ST_FILL : ST_FETCH;
        end
      end
      default: next_state = ST_FILL;
    endcase
  end

  // State register and the flow-control outputs derived from it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_FILL;
      pix_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      state <= next_state;
      pix_ready <= (next_state == ST_FILL);
      out_valid <= (next_state == ST_SEND);
    end
  end

  // Output word and its frame markers, taken from the memory read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data <= 16'h0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
    end else if (state == ST_LOAD) begin
      out_data <= rdata;
      out_sof <= (dr_col == 16'h0) & (dr_row == 16'h0);
      out_eol <= last_col;
    end
  end

  // Region walk counters, restarted when a frame has been stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_col <= 16'h0;
      dr_row <= 16'h0;
    end else if (state == ST_FILL) begin
      dr_col <= 16'h0;
      dr_row <= 16'h0;
    end else if ((state == ST_SEND) & out_ready) begin
      dr_col <= last_col ? 16'h0 : dr_col + 16'h1;
      dr_row <= last_col ? dr_row + 16'h1 : dr_row;
    end
  end

  // Input position, frame tracking, depth capture and increment counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame <= 1'b0;
      in_col <= 16'h0;
      in_row <= 16'h0;
      grey_cnt <= 8'h00;
      depth_lat <= DEPTH_12;
    end else if (take) begin
      if (pix_sof) begin
        in_frame <= 1'b1;
        depth_lat <= ctrl[CTRL_DEPTH_LSB +: 2];
      end
      if (frame_done) begin
        in_frame <= 1'b0;
      end
      in_col <= pix_eol ? 16'h0 : cur_col + 16'h1;
      in_row <= pix_eol ? cur_row + 16'h1 : cur_row;
      grey_cnt <= grey + 8'h01;
    end
  end

  // Reported colour layout follows the mirror settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bayer_layout <= LAYOUT_RG;
    end else begin
      bayer_layout <= BASE_LAYOUT ^ {ctrl[CTRL_MIRROR_ROWS],
                                     ctrl[CTRL_MIRROR_COLS]};
    end
  end

  // ****************************************
  // APB slave
  // ****************************************

  // One wait state: the answer is registered, then pready rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_acc & ~pready;
      if (apb_acc & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_word;
        pslverr <= ~hit;
      end
    end
  end

  // Control and region registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      col_start <= 16'h0;
      row_start <= 16'h0;
      crop_w <= MAXC;
      crop_h <= MAXR;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl <= pwdata[6:0];
      end
      if (sel_cs) begin
        col_start <= pwdata[15:0];
      end
      if (sel_rs) begin
        row_start <= pwdata[15:0];
      end
      if (sel_w) begin
        crop_w <= pwdata[15:0];
      end
      if (sel_h) begin
        crop_h <= pwdata[15:0];
      end
    end
  end

  // Pattern kind writes reach only the generator that is selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_sensor_en <= 1'b0;
      pat_pipe_en <= 1'b0;
    end else if (wr_en & sel_pat) begin
      if (!src_pipe & (wr_kind == KIND_OFF)) begin
        pat_sensor_en <= 1'b0;
      end
      if (!src_pipe & (wr_kind == KIND_SENSOR)) begin
        pat_sensor_en <= 1'b1;
      end
      if (src_pipe & (wr_kind == KIND_OFF)) begin
        pat_pipe_en <= 1'b0;
      end
      if (src_pipe & (wr_kind == KIND_INCREMENT)) begin
        pat_pipe_en <= 1'b1;
      end
    end
  end

endmodule

// file: test/pap_pixel_path_asserts.sv
// Port checker of the pixel path block and its bind.
`timescale 1ns/1ps
module pap_pixel_path_asserts
  import pap_pkg::*;
#(
  parameter logic [1:0] BASE_LAYOUT = LAYOUT_RG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic pix_ready,
  input wire logic out_valid,
  input wire logic [15:0] out_data,
  input wire logic out_sof,
  input wire logic out_eol,
  input wire logic out_ready,
  input wire logic [1:0] bayer_layout
);
  // ****
  // Shadow of the control word
  // ****
  logic wr_ctrl;
  logic [6:0] ctrl_q;
  logic [15:0] dkeep;
  logic [15:0] fkeep;
  // A control write, and the word bits that depth and format keep.
  assign wr_ctrl = pready && pwrite && !pslverr && paddr == OFF_CTRL;
  assign dkeep = ctrl_q[3:2] == DEPTH_10 ? 16'hffc0 :
    ctrl_q[3:2] == DEPTH_14 ? 16'hfffc : 16'hfff0;
  assign fkeep = ctrl_q[5:4] == FMT_8 ? 16'hff00 :
    ctrl_q[5:4] == FMT_10 ? 16'hffc0 :
    ctrl_q[5:4] == FMT_12 ? 16'hfff0 : 16'hffff;
  // Tracks the control word as software writes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[6:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_map_a: assert property (pready |->
    pslverr == (paddr > OFF_STATUS || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for offset");
  bad_read_zero_a: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("unmapped read not zero");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
    $stable(out_data) && $stable({out_sof, out_eol}))
    else $error("output changed while stalled");
  out_gap_a: assert property (out_valid && out_ready |=> !out_valid [*2])
    else $error("output pacing wrong");
  fill_mask_a: assert property (out_valid |->
    (out_data & ~(dkeep & fkeep)) == 16'h0000)
    else $error("low filler bits not zero");
  layout_mirror_a: assert property ($past(presetn) && !wr_ctrl &&
    !$past(wr_ctrl) |-> bayer_layout == (BASE_LAYOUT ^ ctrl_q[1:0]))
    else $error("colour layout wrong");
  drain_stall_a: assert property (out_valid |-> !pix_ready)
    else $error("input open while draining");
  cover property (out_valid && out_ready && out_sof);
  cover property (out_valid && !out_ready);
  cover property (pready && pslverr);
endmodule

bind pap_pixel_path pap_pixel_path_asserts #(.BASE_LAYOUT(BASE_LAYOUT))
  i_pap_pixel_path_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .pix_ready, .out_valid,
  .out_data, .out_sof, .out_eol, .out_ready, .bayer_layout);

// file: test/pap_pixel_source.sv
// Sensor side source and downstream sink facing the pixel path.
`timescale 1ns/1ps
module pap_pixel_source #(
  parameter int MAX_COLS = 16,
  parameter int MAX_ROWS = 17
) (
  input wire logic pclk,
  input wire logic start,
  input wire logic [3:0] seed,
  input wire logic [4:0] full_bits,
  input wire logic stall,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [13:0] pix_data,
  output logic pix_sof,
  output logic pix_eol,
  output logic out_ready
);
  // Sink takes every cycle, or every other cycle while stalling.
  always @(posedge pclk) begin
    out_ready <= !stall || !out_ready;
  end
  // One raster frame per start pulse; released data shows its inverse.
  initial begin
    pix_valid = 1'b0;
    pix_sof = 1'b0;
    pix_eol = 1'b0;
    pix_data = 14'h0;
    forever begin
      @(posedge pclk);
      if (start) begin
        for (int y = 0; y < MAX_ROWS; y++) begin
          for (int x = 0; x < MAX_COLS; x++) begin
            pix_valid <= 1'b1;
            pix_sof <= (x == 0 && y == 0);
            pix_eol <= (x == MAX_COLS - 1);
            pix_data <= (full_bits != 0) ? 14'((1 << full_bits) - 1) :
              14'(((y * MAX_COLS + x) * 3 + seed) & 14'h3ff);
            @(posedge pclk);
            while (pix_ready !== 1'b1) @(posedge pclk);
            if (x == 3 || x == MAX_COLS - 1) begin
              pix_valid <= 1'b0;
              pix_sof <= 1'b0;
              pix_eol <= 1'b0;
              pix_data <= ~pix_data;
              @(posedge pclk);
            end
          end
        end
      end
    end
  end
endmodule

// file: test/test_pap_pixel_path.sv
// Self-checking bench of the pixel path block.
`timescale 1ns/1ps
`define CHECK(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
  end
module test_pap_pixel_path
  import pap_pkg::*;
;
  localparam int MC = 16;
  localparam int MR = 17;
  int num_errors = 0;
  int comparisons = 0;
  int cs = 0, rs = 0, cw = MC, ch = MR;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pix_valid, pix_sof, pix_eol, pix_ready;
  logic out_valid, out_sof, out_eol, out_ready;
  logic [13:0] pix_data;
  logic [15:0] out_data, first_px;
  logic [1:0] bayer_layout;
  logic start = 0, stall = 0, kinc = 0, ksens = 0;
  logic [3:0] seed = 4'h0;
  logic [4:0] full_bits = 5'h0;
  logic [6:0] ctrl = 7'h34;
  // Clock of 10 ns.
  always #5 pclk = ~pclk;
  pap_pixel_path #(.MAX_COLS(MC), .MAX_ROWS(MR)) i_pap_pixel_path (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pix_valid, .pix_data, .pix_sof, .pix_eol,
    .pix_ready, .out_valid, .out_data, .out_sof, .out_eol, .out_ready,
    .bayer_layout);
  pap_pixel_source #(.MAX_COLS(MC), .MAX_ROWS(MR)) i_pap_pixel_source (
    .pclk, .start, .seed, .full_bits, .stall, .pix_ready, .pix_valid,
    .pix_data, .pix_sof, .pix_eol, .out_ready);
  // ****
  // Bus and frame tasks
  // ****
  // One APB transfer; waits for pready, then releases for an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
    input logic xe, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHECK(r, x, m)
    `CHECK(e, xe, m)
  endtask
  task automatic set_ctrl(input logic [6:0] v);
    ctrl = v;
    wr(OFF_CTRL, {25'h0, v});
  endtask
  task automatic set_crop(input int a, input int b, input int w, input int h);
    {cs, rs, cw, ch} = {a, b, w, h};
    wr(OFF_COL_START, 32'(a));
    wr(OFF_ROW_START, 32'(b));
    wr(OFF_CROP_W, 32'(w));
    wr(OFF_CROP_H, 32'(h));
  endtask
  // Expected region pixel after mirroring, pattern choice and alignment.
  function automatic logic [15:0] exp_pix(input int r, input int c);
    int x, y, b, v;
    logic [15:0] m;
    x = ctrl[0] ? MC - 1 - (cs + c) : cs + c;
    y = ctrl[1] ? MR - 1 - (rs + r) : rs + r;
    b = (ctrl[3:2] == 2'h0) ? 10 : (ctrl[3:2] == 2'h2) ? 14 : 12;
    m = ctrl[5:4] == 2'h0 ? 16'hff00 : ctrl[5:4] == 2'h1 ? 16'hffc0 :
      ctrl[5:4] == 2'h2 ? 16'hfff0 : 16'hffff;
    if (kinc) return {8'(y * MC + x), 8'h00};
    v = ksens ? x + y : full_bits != 0 ? (1 << full_bits) - 1 :
      ((y * MC + x) * 3 + seed) & 'h3ff;
    return 16'((v & ((1 << b) - 1)) << (16 - b)) & m;
  endfunction
  // Sends one frame and checks every pixel of the clipped region.
  task automatic frame(input string name);
    int ew, eh, n;
    ew = cs >= MC ? 0 : (cw < MC - cs ? cw : MC - cs);
    eh = rs >= MR ? 0 : (ch < MR - rs ? ch : MR - rs);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    for (int r = 0; r < eh; r++) begin
      for (int c = 0; c < ew; c++) begin
        n = 0;
        do @(negedge pclk); while (!(out_valid && out_ready) && n++ < 5000);
        `CHECK(out_valid, 1'b1, "pixel missing")
        `CHECK(out_data, exp_pix(r, c), "pixel")
        `CHECK({out_sof, out_eol}, {r == 0 && c == 0, c == ew - 1}, "mark")
        if (r == 0 && c == 0) first_px = out_data;
        @(posedge pclk);
      end
    end
    while (pix_ready !== 1'b1) @(posedge pclk);
    $display("Test %s done", name);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rdchk(OFF_CTRL, 32'h34, 1'b0, "ctrl reset");
    rdchk(OFF_CROP_W, MC, 1'b0, "width reset");
    wr(OFF_MAX_COLS, 32'h3);
    rdchk(OFF_MAX_COLS, MC, 1'b0, "max cols");
    rdchk(OFF_MAX_ROWS, MR, 1'b0, "max rows");
    rdchk(8'h24, 32'h0, 1'b1, "unmapped");
    $display("Test regs done");
  endtask
  // Depth only changes while no frame is in flight.
  task automatic t_depth();
    int top[3] = '{65472, 65520, 65532};
    set_crop(0, 0, 2, 1);
    for (int d = 0; d < 3; d++) begin
      set_ctrl({3'h3, 2'(d), 2'h0});
      full_bits <= 5'(d == 0 ? 10 : d == 1 ? 12 : 14);
      frame("full scale");
      `CHECK(first_px, 16'(top[d]), "top code")
    end
    full_bits <= 5'h0;
    set_crop(1, 2, 4, 2);
    for (int f = 0; f < 4; f++) begin
      seed <= 4'(f + 5);
      set_ctrl({1'b0, 2'(f), DEPTH_12, 2'h0});
      frame("format");
    end
  endtask
  task automatic t_mirror();
    set_crop(13, 2, 9, 3);
    stall <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      set_ctrl({3'h3, DEPTH_12, 2'(m)});
      frame("mirror");
      `CHECK(bayer_layout, 2'(m), "layout")
    end
    stall <= 1'b0;
  endtask
  // Patterns run with fixed sensor controls and no auto loops.
  task automatic t_pattern();
    set_crop(0, 0, 5, 2);
    set_ctrl(7'h34);
    wr(OFF_PATTERN, 32'h2);
    rdchk(OFF_PATTERN, 32'h0, 1'b0, "kind refused");
    wr(OFF_PATTERN, 32'h1);
    ksens = 1'b1;
    frame("sensor pattern");
    set_ctrl(7'h74);
    wr(OFF_PATTERN, 32'h2);
    kinc = 1'b1;
    rdchk(OFF_STATUS, 32'h6, 1'b0, "status both on");
    set_crop(0, 15, MC, 2);
    frame("both on wrap");
    frame("repeat");
    wr(OFF_PATTERN, 32'h0);
    kinc = 1'b0;
    frame("sensor kept");
    set_ctrl(7'h34);
    rdchk(OFF_PATTERN, 32'h1, 1'b0, "source kind");
    wr(OFF_PATTERN, 32'h0);
    ksens = 1'b0;
    frame("real");
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 6000 cycles.
  initial begin
    #400000;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    end_of_test();
  end
  // Reset for 8 cycles, then the scenarios.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_depth();
    t_mirror();
    t_pattern();
    end_of_test();
  end
endmodule
